// ===== hdl/lvdrc_pkg.sv
// constants and types for the low-voltage detect and reset control block
//
// Overview of operation
// - supply below warning level sets warning flag; irq if enabled.
// - supply below detect level sets detect flag; then reset or interrupt.
// - detect reset holds chip in reset while supply stays below detect level.
// - detection works only in run, wait, stop; off in low-power modes.
// - detect trip select 0x00 low, 0x01 high; other codes reserved.
// - warning trip select picks one of four ascending levels, codes 0..3.
// - detect reset enable forces chip reset while the detect comparator reads low.
// - detect interrupt enable requests interrupt while detect flag set.
// - warning interrupt enable requests interrupt while warning flag set.
// - acknowledge clears its flag only once supply is above threshold.
// - acknowledge while supply still low leaves flag and interrupt set.
// - power-on supervision stays on except optionally in deepest leak stop.
// - leaving deepest leak stop re-enables supervision during recovery.
// - reset pin driven low on internal resets except very-low-leak wake.
// - long external reset pin pulse wakes device and sets pin source flag.
// - reset pin ignored when flash option byte pin enable is clear.
// - ramp-up: reset, release untrimmed, reassert on trim, release trimmed.
`default_nettype none
package lvdrc_pkg;
    // detect trip select codes
    localparam logic [1:0] LVDRC_DET_LOW   = 2'h0;
    localparam logic [1:0] LVDRC_DET_HIGH  = 2'h1;
    // warning trip select codes, ascending
    localparam logic [1:0] LVDRC_WARN_LOW  = 2'h0;
    localparam logic [1:0] LVDRC_WARN_MID1 = 2'h1;
    localparam logic [1:0] LVDRC_WARN_MID2 = 2'h2;
    localparam logic [1:0] LVDRC_WARN_HIGH = 2'h3;
    // power modes seen by the block
    localparam logic [2:0] LVDRC_MODE_RUN   = 3'h0;
    localparam logic [2:0] LVDRC_MODE_WAIT  = 3'h1;
    localparam logic [2:0] LVDRC_MODE_STOP  = 3'h2;
    localparam logic [2:0] LVDRC_MODE_VLP   = 3'h3;
    localparam logic [2:0] LVDRC_MODE_LLS   = 3'h4;
    localparam logic [2:0] LVDRC_MODE_VLLS  = 3'h5;
    localparam logic [2:0] LVDRC_MODE_DEEPEST = 3'h6;
    // pin filter time, ns, and its cycle count at 125 MHz
    localparam int LVDRC_PIN_FILT_NS  = 100;
    localparam int LVDRC_CLK_MHZ      = 125;
    localparam int LVDRC_PIN_FILT_CYC =
        (LVDRC_PIN_FILT_NS * LVDRC_CLK_MHZ + 999) / 1000;
    localparam logic [7:0] LVDRC_FILT_ZERO = 8'h00;
    // ramp-up sequence, gray-coded along the path
    typedef enum logic [2:0] {
        LVDRC_RAMP_POR    = 3'b000,
        LVDRC_RAMP_UNTRIM = 3'b001,
        LVDRC_RAMP_TRIM   = 3'b011,
        LVDRC_RAMP_DONE   = 3'b010
    } lvdrc_ramp_t;
    typedef struct packed {
        lvdrc_ramp_t ramp;
        logic        detect_flag;
        logic        warning_flag;
        logic        pin_src_flag;
        logic        in_vlls_wake;
        logic        por_off_armed;
        logic [7:0]  pin_cnt;
        logic [1:0]  pin_sync;
        logic [1:0]  det_sync;
        logic [1:0]  warn_sync;
        logic [1:0]  untrim_sync;
        logic [1:0]  trim_sync;
        logic        chip_rst;
        logic        pin_drive;
    } lvdrc_state_t;
endpackage : lvdrc_pkg
`default_nettype wire

// ===== hdl/lvdrc_ctrl.sv
// low-voltage detect, warning and reset control logic
`timescale 1ns/100ps
`default_nettype none
module lvdrc_ctrl
(
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic [2:0] power_mode,
    input  wire logic       detect_reset_en,
    input  wire logic       detect_irq_en,
    input  wire logic       warning_irq_en,
    input  wire logic [1:0] detect_trip_sel,
    input  wire logic [1:0] warning_trip_sel,
    input  wire logic       detect_ack,
    input  wire logic       warning_ack,
    input  wire logic       por_off_in_deepest,
    input  wire logic       below_detect,
    input  wire logic       below_warning,
    input  wire logic       trim_loaded,
    input  wire logic       above_untrimmed,
    input  wire logic       reset_pin_in,
    input  wire logic       reset_pin_enable,
    output logic            detect_flag,
    output logic            warning_flag,
    output logic            lv_irq,
    output logic [1:0]      detect_level,
    output logic [1:0]      warning_level,
    output logic            por_enable,
    output logic            chip_reset,
    output logic            reset_pin_out,
    output logic            reset_pin_oe,
    output logic            pin_reset_flag,
    output logic            pin_wake
);
    lvdrc_pkg::lvdrc_state_t st;
    lvdrc_pkg::lvdrc_state_t next_st;
    logic det_active;
    logic det_low;
    logic warn_low;
    logic pin_low;
    logic pin_fired;
    logic vlls_mode;

    // -------------------------------------------------------------
    // mode qualification
    // -------------------------------------------------------------
    assign det_active = (power_mode == lvdrc_pkg::LVDRC_MODE_RUN)
                     || (power_mode == lvdrc_pkg::LVDRC_MODE_WAIT)
                     || (power_mode == lvdrc_pkg::LVDRC_MODE_STOP);
    assign vlls_mode  = (power_mode == lvdrc_pkg::LVDRC_MODE_VLLS)
                     || (power_mode == lvdrc_pkg::LVDRC_MODE_DEEPEST);
    assign det_low  = st.det_sync[1] && det_active;
    assign warn_low = st.warn_sync[1] && det_active;
    // a disabled pin function never reads as low; our own drive on the
    // wire is masked, so an outside reset during it goes unseen
    assign pin_low  = !st.pin_sync[1] && reset_pin_enable
                   && !st.pin_drive;
    assign pin_fired = st.pin_cnt
        == 8'(lvdrc_pkg::LVDRC_PIN_FILT_CYC);

    // reserved detect codes fall back to the low level
    assign detect_level = (detect_trip_sel == lvdrc_pkg::LVDRC_DET_HIGH)
        ? lvdrc_pkg::LVDRC_DET_HIGH : lvdrc_pkg::LVDRC_DET_LOW;
    assign warning_level = warning_trip_sel;

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        next_st.det_sync  = {st.det_sync[0], below_detect};
        next_st.warn_sync = {st.warn_sync[0], below_warning};
        next_st.pin_sync  = {st.pin_sync[0], reset_pin_in};
        next_st.untrim_sync = {st.untrim_sync[0], above_untrimmed};
        next_st.trim_sync   = {st.trim_sync[0], trim_loaded};
        // flags: set wins over ack; ack only clears above threshold
        if (warning_ack && !warn_low)
        begin
            next_st.warning_flag = 1'b0;
        end
        if (warn_low)
        begin
            next_st.warning_flag = 1'b1;
        end
        if (detect_ack && !det_low)
        begin
            next_st.detect_flag = 1'b0;
        end
        if (det_low)
        begin
            next_st.detect_flag = 1'b1;
        end
        // pin filter counter saturates at the filter width
        if (!pin_low)
        begin
            next_st.pin_cnt = lvdrc_pkg::LVDRC_FILT_ZERO;
        end
        else if (!pin_fired)
        begin
            next_st.pin_cnt = st.pin_cnt + 8'h01;
        end
        if (pin_fired)
        begin
            next_st.pin_src_flag = 1'b1;
        end
        // latch power-on disable choice at entry to deepest stop
        if (power_mode == lvdrc_pkg::LVDRC_MODE_DEEPEST)
        begin
            if (!st.in_vlls_wake)
            begin
                next_st.por_off_armed = por_off_in_deepest;
            end
            next_st.in_vlls_wake = 1'b1;
        end
        else if (vlls_mode)
        begin
            next_st.in_vlls_wake = 1'b1;
        end
        else if (st.chip_rst)
        begin
            // recovery reset issued, supervision back on
            next_st.in_vlls_wake  = 1'b0;
            next_st.por_off_armed = 1'b0;
        end
        if (power_mode != lvdrc_pkg::LVDRC_MODE_DEEPEST)
        begin
            next_st.por_off_armed = 1'b0;
        end
        // ramp-up sequence
        case (st.ramp)
            lvdrc_pkg::LVDRC_RAMP_POR:
            begin
                if (st.untrim_sync[1])
                begin
                    next_st.ramp = lvdrc_pkg::LVDRC_RAMP_UNTRIM;
                end
            end
            lvdrc_pkg::LVDRC_RAMP_UNTRIM:
            begin
                if (st.trim_sync[1])
                begin
                    next_st.ramp = lvdrc_pkg::LVDRC_RAMP_TRIM;
                end
            end
            lvdrc_pkg::LVDRC_RAMP_TRIM:
            begin
                // comparator is now on the trimmed level
                if (!st.det_sync[1])
                begin
                    next_st.ramp = lvdrc_pkg::LVDRC_RAMP_DONE;
                end
            end
            lvdrc_pkg::LVDRC_RAMP_DONE:
            begin
                next_st.ramp = lvdrc_pkg::LVDRC_RAMP_DONE;
            end
            default:
            begin
                next_st.ramp = lvdrc_pkg::LVDRC_RAMP_POR;
            end
        endcase
        // chip reset sources
        // detect reset follows the comparator, not the sticky flag, so
        // software can still acknowledge once the supply is back
        next_st.chip_rst = (next_st.ramp == lvdrc_pkg::LVDRC_RAMP_POR)
            || (next_st.ramp == lvdrc_pkg::LVDRC_RAMP_TRIM)
            || (detect_reset_en && det_low)
            || (next_st.in_vlls_wake && !vlls_mode)
            || pin_fired;
        // held pins block the driven reset on very-low-leak recovery
        next_st.pin_drive = next_st.chip_rst && !pin_fired
            && !next_st.in_vlls_wake;
    end

    // -------------------------------------------------------------
    // state register
    // -------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            st.ramp          <= lvdrc_pkg::LVDRC_RAMP_POR;
            st.detect_flag   <= 1'b0;
            st.warning_flag  <= 1'b0;
            st.pin_src_flag  <= 1'b0;
            st.in_vlls_wake  <= 1'b0;
            st.por_off_armed <= 1'b0;
            st.pin_cnt       <= lvdrc_pkg::LVDRC_FILT_ZERO;
            st.pin_sync      <= 2'h3;
            st.det_sync      <= 2'h0;
            st.warn_sync     <= 2'h0;
            st.untrim_sync   <= 2'h0;
            st.trim_sync     <= 2'h0;
            st.chip_rst      <= 1'b1;
            st.pin_drive     <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    assign detect_flag    = st.detect_flag;
    assign warning_flag   = st.warning_flag;
    assign lv_irq = (st.detect_flag && detect_irq_en)
                 || (st.warning_flag && warning_irq_en);
    assign por_enable     = !st.por_off_armed;
    assign chip_reset     = st.chip_rst;
    assign reset_pin_out  = 1'b0;
    assign reset_pin_oe   = st.pin_drive;
    assign pin_reset_flag = st.pin_src_flag;
    assign pin_wake       = pin_fired;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    property p_warn_set;
        @(posedge mclk) disable iff (!nrst)
        warn_low |=> warning_flag;
    endproperty
    a_warn_set: assert property (p_warn_set)
        else $error("warning flag not set");

    property p_det_set;
        @(posedge mclk) disable iff (!nrst)
        det_low |=> detect_flag;
    endproperty
    a_det_set: assert property (p_det_set)
        else $error("detect flag not set");

    property p_det_hold;
        @(posedge mclk) disable iff (!nrst)
        (det_low && detect_reset_en) |=> chip_reset;
    endproperty
    a_det_hold: assert property (p_det_hold)
        else $error("reset released while below detect");

    property p_mode_off;
        @(posedge mclk) disable iff (!nrst)
        (!det_active && !detect_flag && !detect_ack) |=> !detect_flag;
    endproperty
    a_mode_off: assert property (p_mode_off)
        else $error("detect flag set in low-power mode");

    property p_ack_low;
        @(posedge mclk) disable iff (!nrst)
        (detect_ack && det_low) |=> detect_flag;
    endproperty
    a_ack_low: assert property (p_ack_low)
        else $error("detect flag cleared while low");

    property p_ack_clr;
        @(posedge mclk) disable iff (!nrst)
        (warning_ack && !warn_low) |=> !warning_flag;
    endproperty
    a_ack_clr: assert property (p_ack_clr)
        else $error("warning flag not cleared by ack");

    property p_irq;
        @(posedge mclk) disable iff (!nrst)
        lv_irq == ((detect_flag && detect_irq_en)
                || (warning_flag && warning_irq_en));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt request mismatch");

    property p_pin_flag;
        @(posedge mclk) disable iff (!nrst)
        (!reset_pin_enable)[*3] |=> $stable(pin_reset_flag);
    endproperty
    a_pin_flag: assert property (p_pin_flag)
        else $error("pin flag changed with pin disabled");

    property p_vlls_pin;
        @(posedge mclk) disable iff (!nrst)
        vlls_mode |=> !reset_pin_oe;
    endproperty
    a_vlls_pin: assert property (p_vlls_pin)
        else $error("reset pin driven in very-low-leak wake");

    property p_ramp_trim;
        @(posedge mclk) disable iff (!nrst)
        (st.ramp == lvdrc_pkg::LVDRC_RAMP_TRIM) |-> chip_reset;
    endproperty
    a_ramp_trim: assert property (p_ramp_trim)
        else $error("reset not held after trim load");

    property p_wake_rst;
        @(posedge mclk) disable iff (!nrst)
        (st.in_vlls_wake && !vlls_mode && !st.chip_rst)
            |=> (chip_reset && !reset_pin_oe);
    endproperty
    a_wake_rst: assert property (p_wake_rst)
        else $error("no quiet reset on very-low-leak wake");
endmodule // lvdrc_ctrl
`default_nettype wire

// ===== verification/lvdrc_partner.sv
// behavioural model of the supply comparators and the reset pin wire
`timescale 1ns/100ps
`default_nettype none
module lvdrc_partner
(
    input  wire logic [3:0] supply,
    input  wire logic [1:0] detect_level,
    input  wire logic [1:0] warning_level,
    input  wire logic       ext_low,
    input  wire logic       reset_pin_out,
    input  wire logic       reset_pin_oe,
    output logic            below_detect,
    output logic            below_warning,
    output logic            above_untrimmed,
    output logic            trim_loaded,
    output logic            reset_pin_in
);
    // -------------------------------------------------------------
    // comparators: every detect level sits under every warning level
    // -------------------------------------------------------------
    assign below_detect    = supply < ({2'h0, detect_level} + 4'h2);
    assign below_warning   = supply < ({2'h0, warning_level} + 4'h4);
    // trim load comes one step above the untrimmed trip
    assign above_untrimmed = supply >= 4'h1;
    assign trim_loaded     = supply >= 4'h2;
    // open drain with pull-up: a released wire reads high
    assign reset_pin_in = (reset_pin_oe ? reset_pin_out : 1'b1) & ~ext_low;
endmodule // lvdrc_partner
`default_nettype wire

// ===== verification/lvdrc_ctrl_tb.sv
// self-checking testbench for the low-voltage detect and reset control
`timescale 1ns/100ps
`default_nettype none
module lvdrc_ctrl_tb;
    logic       mclk, nrst, detect_reset_en, detect_irq_en, warning_irq_en;
    logic       detect_ack, warning_ack, por_off_in_deepest, reset_pin_enable;
    logic       below_detect, below_warning, trim_loaded, above_untrimmed;
    logic       reset_pin_in, detect_flag, warning_flag, lv_irq, por_enable;
    logic       chip_reset, reset_pin_out, reset_pin_oe, pin_reset_flag;
    logic       pin_wake, ext_low;
    logic [2:0] power_mode;
    logic [1:0] detect_trip_sel, warning_trip_sel, detect_level, warning_level;
    logic [3:0] supply;
    int         n_errors, tests_run, i;

    lvdrc_ctrl lvdrc_ctrl_inst (.mclk(mclk), .nrst(nrst),
        .power_mode(power_mode), .detect_reset_en(detect_reset_en),
        .detect_irq_en(detect_irq_en), .warning_irq_en(warning_irq_en),
        .detect_trip_sel(detect_trip_sel), .warning_trip_sel(warning_trip_sel),
        .detect_ack(detect_ack), .warning_ack(warning_ack),
        .por_off_in_deepest(por_off_in_deepest), .below_detect(below_detect),
        .below_warning(below_warning), .trim_loaded(trim_loaded),
        .above_untrimmed(above_untrimmed), .reset_pin_in(reset_pin_in),
        .reset_pin_enable(reset_pin_enable), .detect_flag(detect_flag),
        .warning_flag(warning_flag), .lv_irq(lv_irq),
        .detect_level(detect_level), .warning_level(warning_level),
        .por_enable(por_enable), .chip_reset(chip_reset),
        .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
        .pin_reset_flag(pin_reset_flag), .pin_wake(pin_wake));

    lvdrc_partner lvdrc_partner_inst (.supply(supply),
        .detect_level(detect_level), .warning_level(warning_level),
        .ext_low(ext_low), .reset_pin_out(reset_pin_out),
        .reset_pin_oe(reset_pin_oe), .below_detect(below_detect),
        .below_warning(below_warning), .above_untrimmed(above_untrimmed),
        .trim_loaded(trim_loaded), .reset_pin_in(reset_pin_in));

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // outputs are sampled mid-cycle so edge updates have landed
    task automatic wait_n(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask

    task automatic ack_all;
        @(posedge mclk);
        detect_ack  <= 1'b1;
        warning_ack <= 1'b1;
        @(posedge mclk);
        detect_ack  <= 1'b0;
        warning_ack <= 1'b0;
    endtask

    // bounded wait for the chip to leave reset
    task automatic wait_rel;
        for (int k = 0; k < 100 && chip_reset !== 1'b0; k++)
            @(negedge mclk);
        chk(chip_reset, 4'h0);
    endtask

    task automatic test_done;
        $display("checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // hang guard: the sequence needs well under 37500 cycles
    initial
    begin
        #300000;
        n_errors++;
        test_done;
    end

    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial
    begin
        n_errors = 0; tests_run = 0; nrst = 1'b0; supply = 4'h0;
        power_mode = lvdrc_pkg::LVDRC_MODE_RUN; detect_reset_en = 1'b0;
        detect_irq_en = 1'b0; warning_irq_en = 1'b0; detect_ack = 1'b0;
        warning_ack = 1'b0; detect_trip_sel = 2'h0; warning_trip_sel = 2'h0;
        por_off_in_deepest = 1'b0; reset_pin_enable = 1'b1; ext_low = 1'b0;
        wait_n(5);
        chk(detect_flag, 4'h0);
        chk(warning_flag, 4'h0);
        chk(reset_pin_oe, 4'h1);
        chk(por_enable, 4'h1);
        @(posedge mclk) nrst <= 1'b1;
        wait_n(20);
        chk(chip_reset, 4'h1);
        // high detect level, so trim loads while still below it
        @(posedge mclk);
        detect_trip_sel <= 2'h1;
        supply          <= 4'h1;
        wait_n(6);
        chk(chip_reset, 4'h0);
        @(posedge mclk) supply <= 4'h2;
        wait_n(6);
        chk(chip_reset, 4'h1);
        chk(reset_pin_oe, 4'h1);
        @(posedge mclk) supply <= 4'hF;
        wait_rel;
        chk(reset_pin_oe, 4'h0);
        chk(reset_pin_out, 4'h0);
        ack_all;
        for (i = 0; i < 4; i++)
        begin
            @(posedge mclk);
            detect_trip_sel  <= i[1:0];
            warning_trip_sel <= i[1:0];
            wait_n(0);
            chk({2'h0, detect_level}, (i == 1) ? 4'h1 : 4'h0);
            chk({2'h0, warning_level}, i[3:0]);
        end
        @(posedge mclk);
        detect_trip_sel  <= 2'h0;
        warning_trip_sel <= 2'h0;
        warning_irq_en   <= 1'b1;
        supply           <= 4'h3;
        wait_n(5);
        chk(warning_flag, 4'h1);
        chk(lv_irq, 4'h1);
        chk(detect_flag, 4'h0);
        ack_all;
        wait_n(3);
        chk(warning_flag, 4'h1);
        chk(lv_irq, 4'h1);
        @(posedge mclk) warning_irq_en <= 1'b0;
        wait_n(0);
        chk(lv_irq, 4'h0);
        @(posedge mclk) supply <= 4'hF;
        wait_n(4);
        chk(warning_flag, 4'h1);
        ack_all;
        wait_n(2);
        chk(warning_flag, 4'h0);
        @(posedge mclk);
        detect_irq_en <= 1'b1;
        supply        <= 4'h1;
        wait_n(5);
        chk(detect_flag, 4'h1);
        chk(lv_irq, 4'h1);
        chk(chip_reset, 4'h0);
        @(posedge mclk) supply <= 4'hF;
        wait_n(4);
        ack_all;
        wait_n(2);
        chk(detect_flag, 4'h0);
        chk(lv_irq, 4'h0);
        @(posedge mclk);
        detect_irq_en   <= 1'b0;
        detect_reset_en <= 1'b1;
        supply          <= 4'h1;
        wait_n(40);
        chk(chip_reset, 4'h1);
        chk(reset_pin_oe, 4'h1);
        chk(lv_irq, 4'h0);
        @(posedge mclk) supply <= 4'hF;
        wait_rel;
        ack_all;
        @(posedge mclk) detect_reset_en <= 1'b0;
        for (i = 0; i < 5; i++)
        begin
            @(posedge mclk);
            power_mode <= i[2:0];
            supply     <= 4'h1;
            wait_n(5);
            chk(detect_flag, (i < 3) ? 4'h1 : 4'h0);
            @(posedge mclk) supply <= 4'hF;
            wait_n(4);
            ack_all;
        end
        @(posedge mclk);
        power_mode         <= lvdrc_pkg::LVDRC_MODE_STOP;
        por_off_in_deepest <= 1'b1;
        wait_n(3);
        chk(por_enable, 4'h1);
        @(posedge mclk) power_mode <= lvdrc_pkg::LVDRC_MODE_DEEPEST;
        wait_n(3);
        chk(por_enable, 4'h0);
        @(posedge mclk) power_mode <= lvdrc_pkg::LVDRC_MODE_RUN;
        wait_n(1);
        chk(chip_reset, 4'h1);
        chk(por_enable, 4'h1);
        chk(reset_pin_oe, 4'h0);
        wait_rel;
        @(posedge mclk);
        por_off_in_deepest <= 1'b0;
        reset_pin_enable   <= 1'b0;
        ext_low            <= 1'b1;
        wait_n(40);
        chk(pin_wake, 4'h0);
        chk(chip_reset, 4'h0);
        chk(pin_reset_flag, 4'h0);
        @(posedge mclk) ext_low <= 1'b0;
        wait_n(5);
        @(posedge mclk);
        reset_pin_enable <= 1'b1;
        ext_low          <= 1'b1;
        wait_n(lvdrc_pkg::LVDRC_PIN_FILT_CYC + 6);
        chk(pin_wake, 4'h1);
        chk(pin_reset_flag, 4'h1);
        chk(reset_pin_oe, 4'h0);
        @(posedge mclk) ext_low <= 1'b0;
        wait_rel;
        test_done;
    end
endmodule // lvdrc_ctrl_tb
`default_nettype wire
